// ===== hw/sbt_params.svh
// Constants of the 16-bit timer/counter: register offsets, field positions,
// reset values and internal counts. Included by every design file that needs them.
`ifndef SBT_PARAMS_SVH
`define SBT_PARAMS_SVH

// ==================================================================
// Register offsets (byte addresses, one aligned word each)
`define SBT_OFF_CTRL 32'h0000_0000
`define SBT_OFF_CNT_LO 32'h0000_0004
`define SBT_OFF_CNT_HI 32'h0000_0008
`define SBT_OFF_IRQ_STAT 32'h0000_000c
`define SBT_OFF_IRQ_MASK 32'h0000_0010
`define SBT_OFF_PINS 32'h0000_0014

// ==================================================================
// Control register fields
`define SBT_B_RUN 0
`define SBT_B_CLKSEL 1
`define SBT_B_NOSYNC 2
`define SBT_B_OSCEN 3
`define SBT_B_PS_HI 5
`define SBT_B_PS_LO 4
`define SBT_B_SYSOSC 6
`define SBT_B_WIDE 7
`define SBT_CTRL_RESET 8'h00

// ==================================================================
// Pin register fields
`define SBT_PIN_DIR_HI 1
`define SBT_PIN_DIR_LO 0
`define SBT_PIN_LAT_HI 3
`define SBT_PIN_LAT_LO 2
`define SBT_PIN_DIR_RESET 2'h3
`define SBT_PIN_LAT_RESET 2'h0

// ==================================================================
// Counts and answers
`define SBT_COUNT_RESET 16'h0000
`define SBT_COUNT_MAX 16'hffff
`define SBT_ICLK_LAST 2'h3
`define SBT_RESP_OKAY 2'h0
`define SBT_RESP_SLVERR 2'h2

`endif

// ===== hw/sbt_pkg.sv
// Types shared by the timer/counter modules.
// Assumes sbt_params.svh supplies all numeric constants.
package sbt_pkg;

	// ==================================================================
	// Counting mode, decoded from the control register
	typedef enum logic [2:0] {
		SBT_MODE_TIMER = 3'b001,
		SBT_MODE_SYNC = 3'b010,
		SBT_MODE_ASYNC = 3'b100
	} sbt_mode_e;

	typedef logic [7:0] sbt_byte_t;
	typedef logic [15:0] sbt_count_t;
	typedef logic [1:0] sbt_ps_t;

endpackage : sbt_pkg

// ===== hw/sbt_tick_if.sv
// Tick path between the counter core and its prescaler.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface sbt_tick_if;
	import sbt_pkg::*;
	logic tickIn;
	logic clear;
	sbt_ps_t select;
	logic tickOut;

	modport core (output tickIn, output clear, output select, input tickOut);
	modport pre (input tickIn, input clear, input select, output tickOut);
endinterface : sbt_tick_if

// ===== hw/sbt_sync2.sv
// Two-flop synchroniser, one chain per bit.
// Assumes inputs are asynchronous levels from pins or other clock domains.
`timescale 1ns/1ns
module sbt_sync2 #(
	parameter int W = 3
) (
	input wire logic clk, // System clock
	input wire logic sys_rst, // Asynchronous reset, active high
	input wire logic [W-1:0] async, // Raw levels
	output logic [W-1:0] synced // Levels after two flops
);
	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_bit
			logic meta;
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					meta <= 1'b0;
					synced[gi] <= 1'b0;
				end else begin
					meta <= async[gi];
					synced[gi] <= meta;
				end
			end
		end
	endgenerate
endmodule : sbt_sync2

// ===== hw/sbt_prescaler.sv
// Input prescaler: passes every 1st, 2nd, 4th or 8th input tick.
// Assumes the core gates tickIn and pulses clear for one cycle.
`timescale 1ns/1ns
`include "sbt_params.svh"
module sbt_prescaler
	import sbt_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic sys_rst, // Asynchronous reset, active high
	sbt_tick_if.pre tick // Tick in, clear, ratio, tick out
);
	logic [2:0] count;
	logic [2:0] mask;

	// ==================================================================
	// Ratio decode
	always_comb begin
		unique case (tick.select)
			2'h0: mask = 3'h0;
			2'h1: mask = 3'h1;
			2'h2: mask = 3'h3;
			2'h3: mask = 3'h7;
		endcase
	end

	// Emit on the last input of each group
	assign tick.tickOut = tick.tickIn && ((count & mask) == mask); // see R5

	// ==================================================================
	// Internal count, cleared by a low-byte write
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			count <= 3'h0;
		end else if (tick.clear) begin
			count <= 3'h0; // see R11
		end else if (tick.tickIn) begin
			count <= count + 3'h1;
		end
	end
endmodule : sbt_prescaler

// ===== hw/sbt_timer_counter.sv
// 16-bit timer/counter with prescaler, optional buffered 16-bit access,
// crystal oscillator control and an overflow interrupt, on an AXI4-Lite slave.
// Assumes the bus master keeps AXI4-Lite handshakes; pins are asynchronous.
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "sbt_params.svh"

// Overview of operation
// R1: Count only while the run bit is set
// R2: Internal source: count every fourth system clock
// R3: External source: count rising edges on the pin
// R4: No-sync bit picks synchronous or asynchronous mode
// R5: Prescale field divides input by 1,2,4,8
// R6: Oscillator enable bit powers the crystal amplifier
// R7: Read-only bit shows system clock from oscillator
// R8: Wide bit selects 16-bit or byte access
// R9: Low-byte read copies live high byte
// R10: Wide high write loads buffer; low write commits
// R11: Low write clears prescaler, high write not
// R12: Enabled block forces pins input, reads zero
// R13: Oscillator keeps running in power-managed modes
// R14: Software waits for oscillator start-up itself
// R15: Rollover sets overflow flag; enable gates interrupt
// R16: Trigger zeroes count silently; write wins
// R17: Byte mode high address reaches live byte
module sbt_timer_counter
	import sbt_pkg::*;
(
	input wire logic clk, // System clock, 50 MHz
	input wire logic sys_rst, // Asynchronous reset, active high
	input wire logic [31:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte enables
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [31:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	output logic irq, // Overflow interrupt, level
	input wire logic extCountPinI, // Count / amplifier output pin, level in
	output logic extCountPinO, // Count pin port drive value
	output logic extCountPinOe, // Count pin port drive enable
	input wire logic oscInPinI, // Oscillator input pin, level in
	output logic oscInPinO, // Oscillator input pin port drive value
	output logic oscInPinOe, // Oscillator input pin port drive enable
	output logic oscAmpEnable, // Crystal inverter and feedback enable
	input wire logic specialEventTrigger, // Compare-unit reset pulse
	input wire logic powerManagedMode, // Core clocks gated (sleep/idle)
	input wire logic sysClkFromOsc // Clock control selects this oscillator
);
	// ==================================================================
	// Declarations
	sbt_byte_t ctrl;
	sbt_count_t count;
	sbt_byte_t hiBuf;
	logic overflowFlag;
	logic overflowIrqEnable;
	logic [1:0] pinDir;
	logic [1:0] pinLatch;
	logic sysOscStatus;
	logic [2:0] pinSync;
	logic extPrev;
	logic [1:0] iclkCnt;
	logic syncStage;
	sbt_mode_e mode;
	logic awHeld;
	logic wHeld;
	logic [31:0] wAddr;
	logic [7:0] wData;
	logic wLaneLo;
	logic doWrite;
	logic doRead;
	logic wrCtrl;
	logic wrLow;
	logic wrHigh;
	logic wrMask;
	logic wrPins;
	logic rdLow;
	logic rdStatus;
	logic wide;
	logic run;
	logic extRise;
	logic iclkTick;
	logic halted;
	logic incr;
	logic trigReset;
	logic ovfEvent;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	sbt_tick_if tick ();

	// ==================================================================
	// Pin and status synchronisers
	sbt_sync2 #(
		.W(3)
	) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.async({sysClkFromOsc, oscInPinI, extCountPinI}),
		.synced(pinSync)
	);

	sbt_prescaler u_pre (
		.clk(clk),
		.sys_rst(sys_rst),
		.tick(tick)
	);

	// ==================================================================
	// Mode decode
	assign run = ctrl[`SBT_B_RUN];
	assign wide = ctrl[`SBT_B_WIDE];

	always_comb begin
		if (!ctrl[`SBT_B_CLKSEL]) begin
			mode = SBT_MODE_TIMER; // see R4
		end else if (ctrl[`SBT_B_NOSYNC]) begin
			mode = SBT_MODE_ASYNC;
		end else begin
			mode = SBT_MODE_SYNC;
		end
	end

	// ==================================================================
	// Count sources
	// Edge detect reads only the second synchroniser flop
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			extPrev <= 1'b0;
		end else begin
			extPrev <= pinSync[0];
		end
	end
	assign extRise = pinSync[0] && !extPrev; // see R3

	// Instruction-cycle divider: one tick per four system clocks
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			iclkCnt <= 2'h0;
		end else begin
			iclkCnt <= iclkCnt + 2'h1;
		end
	end
	assign iclkTick = (iclkCnt == `SBT_ICLK_LAST); // see R2

	// Synchronised modes stop with the core clock; the asynchronous one keeps counting
	assign halted = powerManagedMode && (mode != SBT_MODE_ASYNC); // see R13

	assign tick.tickIn = run && !halted && (mode == SBT_MODE_TIMER ? iclkTick : extRise); // see R1
	assign tick.select = ctrl[`SBT_B_PS_HI:`SBT_B_PS_LO]; // see R5
	assign tick.clear = wrLow; // see R11

	// Synchronous counter mode takes one more register stage after the prescaler
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			syncStage <= 1'b0;
		end else begin
			syncStage <= tick.tickOut && (mode == SBT_MODE_SYNC);
		end
	end

	always_comb begin
		unique case (mode)
			SBT_MODE_SYNC: incr = run && syncStage; // see R4
			SBT_MODE_TIMER: incr = tick.tickOut;
			SBT_MODE_ASYNC: incr = tick.tickOut;
			default: incr = 1'b0;
		endcase
	end

	// Reset by the compare unit is not honoured in asynchronous mode
	assign trigReset = specialEventTrigger && run && (mode != SBT_MODE_ASYNC); // see R16

	// ==================================================================
	// AXI4-Lite write channel
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			wAddr <= 32'h0000_0000;
			wData <= 8'h00;
			wLaneLo <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SBT_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				wAddr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata[7:0];
				wLaneLo <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (doWrite) begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wAddr == `SBT_OFF_CTRL || wAddr == `SBT_OFF_CNT_LO ||
					wAddr == `SBT_OFF_CNT_HI || wAddr == `SBT_OFF_IRQ_STAT ||
					wAddr == `SBT_OFF_IRQ_MASK || wAddr == `SBT_OFF_PINS) ?
					`SBT_RESP_OKAY : `SBT_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	assign doWrite = awHeld && wHeld && !s_axi_bvalid;
	// Only byte lane 0 carries register data; other lanes are ignored
	assign wrCtrl = doWrite && wLaneLo && (wAddr == `SBT_OFF_CTRL);
	assign wrLow = doWrite && wLaneLo && (wAddr == `SBT_OFF_CNT_LO);
	assign wrHigh = doWrite && wLaneLo && (wAddr == `SBT_OFF_CNT_HI);
	assign wrMask = doWrite && wLaneLo && (wAddr == `SBT_OFF_IRQ_MASK);
	assign wrPins = doWrite && wLaneLo && (wAddr == `SBT_OFF_PINS);

	// ==================================================================
	// AXI4-Lite read channel
	assign doRead = s_axi_arvalid && s_axi_arready;
	assign rdLow = doRead && (s_axi_araddr == `SBT_OFF_CNT_LO);
	assign rdStatus = doRead && (s_axi_araddr == `SBT_OFF_IRQ_STAT);

	always_comb begin
		next_rdata = 32'h0000_0000;
		next_rresp = `SBT_RESP_OKAY;
		unique case (s_axi_araddr)
			`SBT_OFF_CTRL: next_rdata[7:0] = {ctrl[`SBT_B_WIDE], sysOscStatus, ctrl[5:0]}; // see R7
			`SBT_OFF_CNT_LO: next_rdata[7:0] = count[7:0];
			`SBT_OFF_CNT_HI: next_rdata[7:0] = wide ? hiBuf : count[15:8]; // see R8, see R17
			`SBT_OFF_IRQ_STAT: next_rdata[0] = overflowFlag;
			`SBT_OFF_IRQ_MASK: next_rdata[0] = overflowIrqEnable;
			`SBT_OFF_PINS: next_rdata[5:0] = {(run ? 2'h0 : pinSync[1:0]), pinLatch, pinDir}; // see R12
			default: next_rresp = `SBT_RESP_SLVERR;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `SBT_RESP_OKAY;
		end else if (doRead) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ==================================================================
	// Control register and oscillator
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl <= `SBT_CTRL_RESET;
		end else if (wrCtrl) begin
			ctrl <= wData;
		end
	end

	// Amplifier follows only the enable bit, never the power-managed state
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			oscAmpEnable <= 1'b0;
		end else begin
			oscAmpEnable <= ctrl[`SBT_B_OSCEN]; // see R6, see R13
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sysOscStatus <= 1'b0;
		end else begin
			sysOscStatus <= pinSync[2]; // see R7
		end
	end

	// ==================================================================
	// Counter
	// A low-byte write, or a high-byte write in byte mode, beats the trigger and any increment in the same cycle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			count <= `SBT_COUNT_RESET;
		end else if (wrLow) begin
			count <= {(wide ? hiBuf : count[15:8]), wData}; // see R10
		end else if (wrHigh && !wide) begin
			count[15:8] <= wData; // see R17
		end else if (trigReset) begin
			count <= `SBT_COUNT_RESET; // see R16
		end else if (incr) begin
			count <= count + 16'h0001; // see R15
		end
	end

	assign ovfEvent = incr && (count == `SBT_COUNT_MAX) && !wrLow && !(wrHigh && !wide) && !trigReset;

	// High-byte buffer: snapshot on low read, staging on high write
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hiBuf <= 8'h00;
		end else if (wrHigh && wide) begin
			hiBuf <= wData; // see R10
		end else if (rdLow && wide) begin
			hiBuf <= count[15:8]; // see R9
		end
	end

	// ==================================================================
	// Overflow interrupt
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			overflowFlag <= 1'b0;
		end else begin
			overflowFlag <= ovfEvent || (overflowFlag && !rdStatus); // see R15
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			overflowIrqEnable <= 1'b0;
		end else if (wrMask) begin
			overflowIrqEnable <= wData[0];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= overflowFlag && overflowIrqEnable; // see R15
		end
	end

	// ==================================================================
	// Shared port pins
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pinDir <= `SBT_PIN_DIR_RESET;
			pinLatch <= `SBT_PIN_LAT_RESET;
		end else if (wrPins) begin
			pinDir <= wData[`SBT_PIN_DIR_HI:`SBT_PIN_DIR_LO];
			pinLatch <= wData[`SBT_PIN_LAT_HI:`SBT_PIN_LAT_LO];
		end
	end

	// Direction bits are overridden only while counting (run bit set), not while the oscillator alone is enabled
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			extCountPinOe <= 1'b0;
			oscInPinOe <= 1'b0;
			extCountPinO <= 1'b0;
			oscInPinO <= 1'b0;
		end else begin
			extCountPinOe <= !run && !pinDir[0]; // see R12
			oscInPinOe <= !run && !pinDir[1]; // see R12
			extCountPinO <= pinLatch[0];
			oscInPinO <= pinLatch[1];
		end
	end
endmodule : sbt_timer_counter

// ===== bench/sbt_timer_counter_sva.sv
// Port-level assertions for the timer/counter register slave.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/1ns
`include "sbt_params.svh"
module sbt_timer_counter_sva (
	input wire logic clk, // Clock
	input wire logic sys_rst, // Reset
	input wire logic [31:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // AW valid
	input wire logic s_axi_awready, // AW ready
	input wire logic s_axi_wvalid, // W valid
	input wire logic s_axi_wready, // W ready
	input wire logic [1:0] s_axi_bresp, // B response
	input wire logic s_axi_bvalid, // B valid
	input wire logic s_axi_bready, // B ready
	input wire logic [31:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // AR valid
	input wire logic s_axi_arready, // AR ready
	input wire logic [31:0] s_axi_rdata, // Read data
	input wire logic [1:0] s_axi_rresp, // R response
	input wire logic s_axi_rvalid, // R valid
	input wire logic s_axi_rready, // R ready
	input wire logic oscAmpEnable // Amplifier enable
);
	// ==================================================================
	// Helpers
	localparam logic [31:0] LAST = `SBT_OFF_PINS;
	logic awTake;
	logic arTake;
	assign awTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign arTake = s_axi_arvalid && s_axi_arready;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// ==================================================================
	// Properties
	property p_b_latency;
		awTake |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_b_latency: assert property (p_b_latency) else $error("write response late");
	property p_r_latency;
		arTake |=> s_axi_rvalid;
	endproperty
	a_r_latency: assert property (p_r_latency) else $error("read data late");
	property p_b_stand;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_stand: assert property (p_b_stand) else $error("write response dropped");
	property p_r_stand;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
	endproperty
	a_r_stand: assert property (p_r_stand) else $error("read data dropped");
	property p_w_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_w_block: assert property (p_w_block) else $error("write accepted while busy");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read accepted while busy");
	property p_bad_write;
		awTake && (s_axi_awaddr > LAST || s_axi_awaddr[1:0] != 2'h0)
			|-> ##[1:2] (s_axi_bvalid && s_axi_bresp == `SBT_RESP_SLVERR);
	endproperty
	a_bad_write: assert property (p_bad_write) else $error("unmapped write not refused");
	property p_bad_read;
		arTake && s_axi_araddr > LAST |=> s_axi_rresp == `SBT_RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	a_bad_read: assert property (p_bad_read) else $error("unmapped read not refused");
	// Amplifier only moves as a consequence of a completed register write
	property p_osc_cause;
		$changed(oscAmpEnable) |-> $past(s_axi_bvalid) || s_axi_bvalid;
	endproperty
	a_osc_cause: assert property (p_osc_cause) else $error("amplifier changed without write");
endmodule : sbt_timer_counter_sva

bind sbt_timer_counter sbt_timer_counter_sva u_sva (.clk(clk), .sys_rst(sys_rst),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.oscAmpEnable(oscAmpEnable));

// ===== bench/sbt_clk_model.sv
// External count source and crystal stand-in on the two counter pins.
// Assumes the pins are pulled low whenever nothing drives them.
`timescale 1ns/1ns
module sbt_clk_model (
	input wire logic clk, // Pacing clock
	input wire logic [7:0] burstLen, // Rising edges per burst
	input wire logic burstGo, // Start a burst
	input wire logic oscAmpEnable, // Crystal amplifier powered
	output logic extCountPinI, // Count pin level
	output logic oscInPinI, // Oscillator input level
	output logic busy // Burst running
);
	logic [7:0] left = 8'h0;
	logic [3:0] phase = 4'h0;
	// Eight clocks high and low so the synchroniser never misses an edge
	always_ff @(posedge clk) begin
		phase <= phase + 4'h1;
		if (burstGo) begin
			left <= burstLen;
		end else if (phase == 4'hf && left != 8'h0) begin
			left <= left - 8'h1;
		end
	end
	// A crystal without its amplifier does not swing
	assign oscInPinI = oscAmpEnable & phase[2];
	assign extCountPinI = (left != 8'h0 && phase[3]) | (oscAmpEnable & ~phase[2]);
	assign busy = left != 8'h0;
endmodule : sbt_clk_model

// ===== bench/sixteen_bit_timer_counter_bench.sv
// Register-level bench for the timer/counter over AXI4-Lite.
// Assumes sbt_clk_model on the pins and a 50 MHz clock.
`timescale 1ns/1ns
`include "sbt_params.svh"
module sixteen_bit_timer_counter_bench;
	// ==================================================================
	// Signals
	localparam logic [31:0] CT = `SBT_OFF_CTRL;
	localparam logic [31:0] LO = `SBT_OFF_CNT_LO;
	localparam logic [31:0] HI = `SBT_OFF_CNT_HI;
	localparam logic [31:0] ST = `SBT_OFF_IRQ_STAT;
	localparam logic [31:0] MK = `SBT_OFF_IRQ_MASK;
	localparam logic [31:0] PN = `SBT_OFF_PINS;
	logic clk = 1'b0;
	logic sys_rst, awv, wv, bre, arv, rre, go, sco, pmm, trig;
	logic awr, wrd, bv, arr, rv, irq, cpi, cpo, cpe, opi, opo, ope, amp, busy;
	logic [1:0] br, rr, r;
	logic [31:0] awa, wd, ara, rd, d;
	logic [7:0] len;
	int badCount = 0;
	int totalChecks = 0;
	int lag = 0;
	always #10 clk = ~clk;

	sbt_timer_counter u_dut (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wrd),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
		.irq(irq), .extCountPinI(cpi), .extCountPinO(cpo), .extCountPinOe(cpe), .oscInPinI(opi),
		.oscInPinO(opo), .oscInPinOe(ope), .oscAmpEnable(amp), .specialEventTrigger(trig),
		.powerManagedMode(pmm), .sysClkFromOsc(sco));
	sbt_clk_model u_src (.clk(clk), .burstLen(len), .burstGo(go), .oscAmpEnable(amp),
		.extCountPinI(cpi), .oscInPinI(opi), .busy(busy));

	// ==================================================================
	// Tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			badCount++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic summarize;
		if (badCount == 0 && totalChecks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : summarize
	// Response ready may lag by lag cycles to exercise a stalled master
	task automatic wreg(input logic [31:0] a, input logic [7:0] v, output logic [1:0] q);
		bit ad = 0;
		bit dd = 0;
		@(posedge clk);
		awa <= a;
		wd <= {24'h0, v};
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= (lag == 0);
		while (!(ad && dd)) begin
			@(posedge clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wrd) wv <= 1'b0;
			ad = ad | (awv && awr);
			dd = dd | (wv && wrd);
		end
		repeat (lag) @(posedge clk);
		bre <= 1'b1;
		do @(posedge clk); while (!bv);
		q = br;
		bre <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [31:0] a, output logic [31:0] v, output logic [1:0] q);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rre <= (lag == 0);
		do @(posedge clk); while (!arr);
		arv <= 1'b0;
		repeat (lag) @(posedge clk);
		rre <= 1'b1;
		do @(posedge clk); while (!rv);
		v = rd;
		q = rr;
		rre <= 1'b0;
	endtask : rreg
	task automatic w(input logic [31:0] a, input logic [7:0] v);
		logic [1:0] q;
		wreg(a, v, q);
	endtask : w
	task automatic rc(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] v;
		logic [1:0] q;
		rreg(a, v, q);
		chk(v, e);
	endtask : rc
	task automatic pulse(input logic [7:0] n);
		@(posedge clk);
		len <= n;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		do @(posedge clk); while (busy);
		repeat (8) @(posedge clk);
	endtask : pulse

	// ==================================================================
	// Sequence
	initial begin
		{sys_rst, awv, wv, bre, arv, rre, go, sco, pmm, trig} = 10'h200;
		{awa, wd, ara, len} = '0;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		rc(CT, 32'h0);
		rc(PN, 32'h3);
		w(PN, 8'h0c);
		repeat (2) @(posedge clk);
		chk({cpe, ope, cpo, opo}, 4'hf);
		w(CT, 8'h01);
		repeat (2) @(posedge clk);
		chk({cpe, ope}, 2'h0);
		rc(PN, 32'h0c);
		w(PN, 8'h03);
		// Stop the timer so each ratio's window opens at its own run write
		w(CT, 8'h00);
		for (int p = 0; p < 4; p++) begin
			w(HI, 8'h0);
			w(LO, 8'h0);
			w(CT, {2'h0, p[1:0], 4'h1});
			repeat (256) @(posedge clk);
			w(CT, {2'h0, p[1:0], 4'h0});
			rreg(LO, d, r);
			chk(d inside {[(64 >> p) - 1 : (64 >> p) + 1]}, 1);
		end
		repeat (50) @(posedge clk);
		rc(LO, d);
		for (int s = 0; s < 2; s++) begin
			w(LO, 8'h0);
			w(CT, {5'h0, s[0], 2'h3});
			pulse(8'd10);
			rc(LO, 32'ha);
		end
		w(CT, 8'h13);
		w(LO, 8'h0);
		pulse(8'd10);
		rc(LO, 32'h5);
		w(LO, 8'h0);
		w(CT, 8'h0f);
		pmm <= 1'b1;
		// Count crystal edges for 200 clocks with power-managed mode set
		repeat (200) @(posedge clk);
		chk(amp, 1);
		rreg(LO, d, r);
		chk(d inside {[8'h14 : 8'h1c]}, 1);
		pmm <= 1'b0;
		w(CT, 8'h80);
		// The amplifier enable lags the control write by one clock
		@(posedge clk);
		chk(amp, 0);
		w(HI, 8'hab);
		w(LO, 8'hcd);
		w(CT, 8'h00);
		rc(HI, 32'hab);
		rc(LO, 32'hcd);
		w(CT, 8'h80);
		w(HI, 8'h55);
		rc(HI, 32'h55);
		rc(LO, 32'hcd);
		rc(HI, 32'hab);
		w(CT, 8'h00);
		rc(HI, 32'hab);
		w(HI, 8'h12);
		rc(HI, 32'h12);
		for (int m = 0; m < 2; m++) begin
			w(MK, m[7:0]);
			w(HI, 8'hff);
			w(LO, 8'hfe);
			w(CT, 8'h01);
			repeat (30) @(posedge clk);
			w(CT, 8'h00);
			chk(irq, m[0]);
			rc(HI, 32'h0);
			rc(ST, 32'h1);
			@(posedge clk);
			chk(irq, 0);
			rc(ST, 32'h0);
		end
		w(HI, 8'h12);
		w(CT, 8'h01);
		trig <= 1'b1;
		@(posedge clk);
		trig <= 1'b0;
		w(CT, 8'h00);
		rc(HI, 32'h0);
		rc(ST, 32'h0);
		sco <= 1'b1;
		w(CT, 8'h00);
		rc(CT, 32'h40);
		sco <= 1'b0;
		w(CT, 8'h40);
		rc(CT, 32'h0);
		lag = 3;
		wreg(32'h40, 8'h1, r);
		chk(r, `SBT_RESP_SLVERR);
		rreg(32'h40, d, r);
		chk(r, `SBT_RESP_SLVERR);
		chk(d, 32'h0);
		summarize();
	end
	initial begin
		repeat (20000) @(posedge clk);
		badCount++;
		summarize();
	end
endmodule : sixteen_bit_timer_counter_bench
